//--- rtl/cbt_pin_sync.sv
// channel pin synchroniser with level and rising-edge outputs
`timescale 1ns/1ns
`default_nettype none
module cbt_pin_sync (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic pin_in,
    output logic      level_q,
    output logic      rise
);
    logic meta_q;
    logic prev_q;

    // edge taken only from the second stage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_q  <= 1'b0;
            level_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            meta_q  <= pin_in;
            level_q <= meta_q;
            prev_q  <= level_q;
        end
    end

    assign rise = level_q & ~prev_q;
endmodule : cbt_pin_sync
`default_nettype wire

//--- rtl/cbt_pkg.sv
// package: register map, field layout and constants for the counter/timer channel
package cbt_pkg;

    // ******************************
    // register offsets
    // ******************************
    localparam logic [15:0] OFS_CONTROL    = 16'h0014;
    localparam logic [15:0] OFS_LATCH_LOW  = 16'h0015;
    localparam logic [15:0] OFS_LATCH_HIGH = 16'h0016;
    localparam logic [15:0] OFS_LATCH_LOAD = 16'h0017;

    // ******************************
    // control register fields
    // ******************************
    localparam int BIT_PRESCALE   = 2;
    localparam int BIT_VECTOR_RAM = 5;
    localparam int BIT_IRQ_ENABLE = 6;
    localparam int BIT_UNDERFLOW  = 7;
    localparam logic [7:0] CONTROL_WR_MASK = 8'h64;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;

    // ******************************
    // timing
    // ******************************
    localparam int PRESCALE_DIV = 32;
    localparam int PRESCALE_W   = $clog2(PRESCALE_DIV);
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE_DIV - 1);

    typedef enum logic [1:0] {
        MODE_INTERVAL = 2'b00,
        MODE_PULSE    = 2'b01,
        MODE_EVENT    = 2'b10,
        MODE_WIDTH    = 2'b11
    } cbt_mode_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } cbt_bus_req_t;

endpackage : cbt_pkg

//--- rtl/cbt_prescale.sv
// shared divide-by-32 prescaler producing a one-cycle tick
`timescale 1ns/1ns
`default_nettype none
module cbt_prescale (
    input  wire logic clk_sys,
    input  wire logic resetn,
    output logic      tick_q
);
    logic [cbt_pkg::PRESCALE_W-1:0] div_q;

    // free running so both channels see the same phase
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= (div_q == cbt_pkg::PRESCALE_LAST);
        end
    end
endmodule : cbt_prescale
`default_nettype wire

//--- rtl/cbt_top.sv
// 16-bit down counter/timer channel with control register and pin logic
// Summary of operation
// - reset clears control bits 2, 5, 6; processor writes them at the control address.
// - control reads return bits 2 and 5-7; bits 0, 1, 3, 4 read zero.
// - prescale bit one counts on clock divided by 32, zero on undivided clock.
// - bit 5 routes an enabled interrupt through the RAM vector, else the ROM vector.
// - interrupt request asserts only while enable bit 6 and the underflow flag are set.
// - underflow flag sets when the counter is decremented while at zero.
// - reading the upper-latch-with-load address clears the underflow flag.
// - interval mode: upper latch write loads counter, then decrement per selected tick.
// - interval mode: zero pass sets flag, reloads from latch and keeps counting.
// - pulse mode: upper latch write drives pin low and starts counting.
// - pulse mode: pin toggles at each zero pass, giving a square wave.
// - pulse mode: each zero pass reloads the counter and sets the flag.
// - event mode: load on load-address write, decrement on each pin rising edge.
// - event mode: zero pass sets the flag and reloads in the same step.
// - width mode: decrement at selected rate only while pin low, hold while high.
// - width mode: zero pass sets flag and reloads; counting goes on while low.
// - one shared divide-by-32 prescaler, selected independently by each channel.
// - second channel supports interval mode only, with no pin output option; this channel runs all four modes and drives its pin in pulse mode.
// - load-address write copies both latch bytes to counter and clears the flag.
// - lower count read snapshots upper count byte; upper latch addresses read snapshot.
`timescale 1ns/1ns
`default_nettype none
module cbt_top (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire cbt_pkg::cbt_bus_req_t bus_req,
    input  wire cbt_pkg::cbt_mode_t    timer_mode,
    input  wire logic                  chan_b_pin_in,
    output logic [7:0]                 bus_rdata_q,
    output logic                       chan_b_pin_out_q,
    output logic                       chan_b_pin_oe_n_q,
    output logic                       chan_b_irq_line_q,
    output logic                       irq_ram_vector_q,
    output logic                       irq_rom_vector_q
);

    // ******************************
    // address decode
    // ******************************
    logic       wr_ctrl;
    logic       wr_low;
    logic       wr_high;
    logic       wr_load;
    logic       rd_ctrl;
    logic       rd_low;
    logic       rd_high;
    logic       rd_load;
    logic       hi_write;
    logic       do_load;

    function automatic logic hit(input cbt_pkg::cbt_bus_req_t r, input logic [15:0] ofs);
        return r.addr == ofs;
    endfunction : hit

    assign wr_ctrl = bus_req.wr & hit(bus_req, cbt_pkg::OFS_CONTROL);
    assign wr_low  = bus_req.wr & hit(bus_req, cbt_pkg::OFS_LATCH_LOW);
    assign wr_high = bus_req.wr & hit(bus_req, cbt_pkg::OFS_LATCH_HIGH);
    assign wr_load = bus_req.wr & hit(bus_req, cbt_pkg::OFS_LATCH_LOAD);
    assign rd_ctrl = bus_req.rd & hit(bus_req, cbt_pkg::OFS_CONTROL);
    assign rd_low  = bus_req.rd & hit(bus_req, cbt_pkg::OFS_LATCH_LOW);
    assign rd_high = bus_req.rd & hit(bus_req, cbt_pkg::OFS_LATCH_HIGH);
    assign rd_load = bus_req.rd & hit(bus_req, cbt_pkg::OFS_LATCH_LOAD);
    assign hi_write = wr_high | wr_load;

    // counted modes load on any upper latch write; input modes only on the load address
    always_comb begin
        unique case (timer_mode)
            cbt_pkg::MODE_INTERVAL: do_load = hi_write;
            cbt_pkg::MODE_PULSE:    do_load = hi_write;
            cbt_pkg::MODE_EVENT:    do_load = wr_load;
            cbt_pkg::MODE_WIDTH:    do_load = wr_load;
        endcase
    end

    // ******************************
    // shared prescaler and pin input
    // ******************************
    logic pre_tick;
    logic pin_level;
    logic pin_rise;

    cbt_prescale u_prescale (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .tick_q  (pre_tick)
    );

    cbt_pin_sync u_pin_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .pin_in  (chan_b_pin_in),
        .level_q (pin_level),
        .rise    (pin_rise)
    );

    // ******************************
    // control register
    // ******************************
    logic [7:0] ctrl_q;
    logic       flag_q;
    logic       chan_b_prescale_sel;
    logic       chan_b_irq_enable;
    logic       vector_ram_sel;

    assign chan_b_prescale_sel = ctrl_q[cbt_pkg::BIT_PRESCALE];
    assign chan_b_irq_enable   = ctrl_q[cbt_pkg::BIT_IRQ_ENABLE];
    assign vector_ram_sel      = ctrl_q[cbt_pkg::BIT_VECTOR_RAM];

    // bits 0-1 of this channel have no storage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= cbt_pkg::CONTROL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= bus_req.wdata & cbt_pkg::CONTROL_WR_MASK;
        end
    end

    // ******************************
    // latch, counter and snapshot
    // ******************************
    logic [7:0]  latch_low_q;
    logic [7:0]  latch_high_q;
    logic [15:0] count_q;
    logic [7:0]  snap_q;
    logic        running_q;
    logic        rate_tick;
    logic        dec;
    logic        zero_pass;
    logic [15:0] latch_now;

    assign latch_now = {latch_high_q, latch_low_q};
    assign rate_tick = chan_b_prescale_sel ? pre_tick : 1'b1;

    always_comb begin
        unique case (timer_mode)
            cbt_pkg::MODE_INTERVAL: dec = running_q & rate_tick;
            cbt_pkg::MODE_PULSE:    dec = running_q & rate_tick;
            cbt_pkg::MODE_EVENT:    dec = running_q & pin_rise;
            cbt_pkg::MODE_WIDTH:    dec = running_q & rate_tick & ~pin_level;
        endcase
    end

    assign zero_pass = dec & (count_q == cbt_pkg::COUNT_RESET);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latch_low_q  <= cbt_pkg::BYTE_RESET;
            latch_high_q <= cbt_pkg::BYTE_RESET;
        end else begin
            if (wr_low) begin
                latch_low_q <= bus_req.wdata;
            end
            if (hi_write) begin
                latch_high_q <= bus_req.wdata;
            end
        end
    end

    // a load takes the freshly written upper byte, not the stale latch
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_q   <= cbt_pkg::COUNT_RESET;
            running_q <= 1'b0;
        end else if (do_load) begin
            count_q   <= {bus_req.wdata, latch_low_q};
            running_q <= 1'b1;
        end else if (zero_pass) begin
            count_q <= latch_now;
        end else if (dec) begin
            count_q <= count_q - 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            snap_q <= cbt_pkg::BYTE_RESET;
        end else if (rd_low) begin
            snap_q <= count_q[15:8];
        end
    end

    // ******************************
    // underflow flag
    // ******************************
    // a zero pass in the same cycle as a clear keeps the flag set
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else if (zero_pass) begin
            flag_q <= 1'b1;
        end else if (rd_load | wr_load) begin
            flag_q <= 1'b0;
        end
    end

    // ******************************
    // read data
    // ******************************
    logic [7:0] rd_mux;

    always_comb begin
        rd_mux = 8'h00;
        if (rd_ctrl) begin
            rd_mux = ctrl_q & cbt_pkg::CONTROL_WR_MASK;
            rd_mux[cbt_pkg::BIT_UNDERFLOW] = flag_q;
        end else if (rd_low) begin
            rd_mux = count_q[7:0];
        end else if (rd_high | rd_load) begin
            rd_mux = snap_q;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bus_rdata_q <= 8'h00;
        end else if (bus_req.rd) begin
            bus_rdata_q <= rd_mux;
        end
    end

    // ******************************
    // pin output
    // ******************************
    // the pin is only driven in pulse mode; other modes leave it as an input
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_b_pin_out_q  <= 1'b0;
            chan_b_pin_oe_n_q <= 1'b1;
        end else begin
            chan_b_pin_oe_n_q <= (timer_mode != cbt_pkg::MODE_PULSE);
            if (timer_mode == cbt_pkg::MODE_PULSE) begin
                if (do_load) begin
                    chan_b_pin_out_q <= 1'b0;
                end else if (zero_pass) begin
                    chan_b_pin_out_q <= ~chan_b_pin_out_q;
                end
            end
        end
    end

    // ******************************
    // interrupt request
    // ******************************
    logic irq_d;

    assign irq_d = chan_b_irq_enable & flag_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_b_irq_line_q <= 1'b0;
            irq_ram_vector_q  <= 1'b0;
            irq_rom_vector_q  <= 1'b0;
        end else begin
            chan_b_irq_line_q <= irq_d;
            irq_ram_vector_q  <= irq_d & vector_ram_sel;
            irq_rom_vector_q  <= irq_d & ~vector_ram_sel;
        end
    end

    // ******************************
    // assertions
    // ******************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_ctrl_write_mask: assert property (wr_ctrl |=>
            ctrl_q == ($past(bus_req.wdata) & cbt_pkg::CONTROL_WR_MASK))
        else $error("control write not stored under mask");
    a_ctrl_read_zero: assert property (rd_ctrl |=>
            bus_rdata_q[4:3] == 2'b00 && bus_rdata_q[1:0] == 2'b00)
        else $error("unused control bits read nonzero");
    a_ctrl_read_flag: assert property (rd_ctrl |=>
            bus_rdata_q[cbt_pkg::BIT_UNDERFLOW] == $past(flag_q))
        else $error("control read lost the underflow flag");
    a_irq_gated_enable: assert property (!chan_b_irq_enable [*2] |-> !chan_b_irq_line_q)
        else $error("interrupt raised while disabled");
    a_irq_follow_flag: assert property (chan_b_irq_enable && flag_q |=>
            chan_b_irq_line_q)
        else $error("enabled flag did not raise interrupt");
    a_irq_vector_route: assert property (chan_b_irq_line_q |->
            irq_ram_vector_q != irq_rom_vector_q)
        else $error("interrupt vector routing wrong");
    a_irq_vector_sel: assert property (chan_b_irq_line_q |->
            irq_ram_vector_q == $past(vector_ram_sel))
        else $error("interrupt took the wrong vector");
    a_flag_on_wrap: assert property (zero_pass |=> flag_q)
        else $error("zero pass did not set the flag");
    a_zero_pass_reload: assert property (zero_pass && !do_load |=>
            flag_q && count_q == $past(latch_now))
        else $error("zero pass did not reload and flag");
    a_flag_read_clear: assert property (rd_load && !zero_pass |=> !flag_q)
        else $error("load address read did not clear flag");
    a_load_flag_clear: assert property (wr_load && !zero_pass |=> !flag_q)
        else $error("load address write did not clear flag");
    a_load_copy: assert property (wr_load |=> running_q
            && count_q == {$past(bus_req.wdata), $past(latch_low_q)})
        else $error("load address write did not copy the latch");
    a_pulse_pin_low: assert property (timer_mode == cbt_pkg::MODE_PULSE && do_load
            |=> !chan_b_pin_out_q)
        else $error("pulse start did not drive pin low");
    a_pulse_pin_toggle: assert property (timer_mode == cbt_pkg::MODE_PULSE && zero_pass
            && !do_load |=> chan_b_pin_out_q != $past(chan_b_pin_out_q))
        else $error("pin did not toggle at zero pass");
    a_width_hold_high: assert property (timer_mode == cbt_pkg::MODE_WIDTH && pin_level
            && !do_load |=> $stable(count_q))
        else $error("width counter moved while pin high");
    a_undivided_step: assert property (running_q && !chan_b_prescale_sel && !do_load
            && count_q != 16'h0000 && timer_mode == cbt_pkg::MODE_INTERVAL
            |=> count_q == $past(count_q) - 16'h0001)
        else $error("undivided interval count did not step");
    a_divided_hold: assert property (running_q && chan_b_prescale_sel && !pre_tick
            && !do_load && timer_mode != cbt_pkg::MODE_EVENT |=> $stable(count_q))
        else $error("divided count moved without a prescale tick");
    a_event_step: assert property (timer_mode == cbt_pkg::MODE_EVENT && running_q
            && pin_rise && !do_load && count_q != 16'h0000
            |=> count_q == $past(count_q) - 16'h0001)
        else $error("event count did not step on a rising edge");
    a_event_hold: assert property (timer_mode == cbt_pkg::MODE_EVENT && !pin_rise
            && !do_load |=> $stable(count_q))
        else $error("event count moved without a rising edge");
    a_snapshot_take: assert property (rd_low |=> snap_q == $past(count_q[15:8]))
        else $error("snapshot not taken on low count read");
    a_pin_idle_input: assert property (timer_mode != cbt_pkg::MODE_PULSE
            |=> chan_b_pin_oe_n_q)
        else $error("pin driven outside pulse mode");
    a_sync_rise: assert property (pin_rise |->
            $past(chan_b_pin_in, 2) && !$past(chan_b_pin_in, 3))
        else $error("pin edge not taken from the synchronised value");

    c_interval_wrap: cover property (timer_mode == cbt_pkg::MODE_INTERVAL && zero_pass);
    c_pulse_toggle: cover property (timer_mode == cbt_pkg::MODE_PULSE && zero_pass
            && chan_b_prescale_sel);
    c_event_edge: cover property (timer_mode == cbt_pkg::MODE_EVENT && pin_rise && dec);
    c_width_wrap: cover property (timer_mode == cbt_pkg::MODE_WIDTH && zero_pass);
    c_irq_raised: cover property (chan_b_irq_line_q && irq_ram_vector_q);

endmodule : cbt_top
`default_nettype wire

//--- test/cbt_pin_model.sv
// partner model: external source driving the channel pin
`timescale 1ns/1ns
`default_nettype none
module cbt_pin_model (
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic level_hi,
    input  wire logic pulse_go,
    output logic      pin_level
);
    logic [3:0] left_q;

    // ****
    // pulse: 4 high then 4 low, far slower than half the timer clock
    // ****
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            left_q <= 4'h0;
        end else if (pulse_go && left_q == 4'h0) begin
            left_q <= 4'h8;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end

    assign pin_level = level_hi | (left_q > 4'h4);
endmodule : cbt_pin_model
`default_nettype wire

//--- test/tb.sv
// testbench for the counter/timer channel
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic                  clk_sys = 1'b0;
    logic                  resetn = 1'b0;
    cbt_pkg::cbt_bus_req_t bus_req = '0;
    cbt_pkg::cbt_mode_t    timer_mode = cbt_pkg::MODE_INTERVAL;
    logic                  level_hi = 1'b0;
    logic                  pulse_go = 1'b0;
    logic                  model_level;
    logic                  pin_wire;
    logic [7:0]            rdata;
    logic                  pin_out;
    logic                  oe_n;
    logic                  irq;
    logic                  ram_v;
    logic                  rom_v;
    logic [7:0]            d;
    logic [7:0]            n;
    int                    num_errors = 0;
    int                    samples_checked = 0;
    int                    cycles = 0;
    int                    k;
    integer                seed = 32'h7e3f;

    always #4 clk_sys = ~clk_sys;

    cbt_top cbt_top_inst (
        .clk_sys           (clk_sys),
        .resetn            (resetn),
        .bus_req           (bus_req),
        .timer_mode        (timer_mode),
        .chan_b_pin_in     (pin_wire),
        .bus_rdata_q       (rdata),
        .chan_b_pin_out_q  (pin_out),
        .chan_b_pin_oe_n_q (oe_n),
        .chan_b_irq_line_q (irq),
        .irq_ram_vector_q  (ram_v),
        .irq_rom_vector_q  (rom_v)
    );

    cbt_pin_model cbt_pin_model_inst (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .level_hi  (level_hi),
        .pulse_go  (pulse_go),
        .pin_level (model_level)
    );

    // the wire follows whoever drives it
    assign pin_wire = (oe_n == 1'b0) ? pin_out : model_level;

    // ****
    // helpers
    // ****
    task automatic end_sim();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // square-wave half period: latch plus the wrap step, in timer clocks
    function automatic logic [15:0] exp_gap(input logic [7:0] ld, input logic div);
        return (16'(ld) + 16'h0001) * (div ? 16'(cbt_pkg::PRESCALE_DIV) : 16'h0001);
    endfunction : exp_gap

    // one idle edge after each access keeps strobes apart
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] v);
        bus_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req <= '0;
        @(posedge clk_sys);
    endtask : bus_wr

    task automatic bus_rd(input logic [15:0] a, output logic [7:0] v);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req <= '0;
        @(posedge clk_sys);
        v = rdata;
    endtask : bus_rd

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        bus_rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask : rd_chk

    task automatic load(input logic [7:0] lo, input logic [7:0] hi);
        bus_wr(cbt_pkg::OFS_LATCH_LOW, lo);
        bus_wr(cbt_pkg::OFS_LATCH_LOAD, hi);
    endtask : load

    task automatic toggle_gap(output int gap);
        logic last;
        last = pin_out;
        gap = 0;
        while (pin_out === last && gap < 5000) begin
            @(posedge clk_sys);
            gap++;
        end
        last = pin_out;
        gap = 0;
        while (pin_out === last && gap < 5000) begin
            @(posedge clk_sys);
            gap++;
        end
    endtask : toggle_gap

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    // ****
    // main sequence
    // ****
    initial begin
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd_chk(cbt_pkg::OFS_CONTROL, 8'h00);
        bus_wr(cbt_pkg::OFS_CONTROL, 8'hFF);
        rd_chk(cbt_pkg::OFS_CONTROL, 8'h64);
        rd_chk(16'h0018, 8'h00);
        // prescale off before the timed loads, the mask test above set it
        bus_wr(cbt_pkg::OFS_CONTROL, 8'h00);
        for (int v = 0; v < 2; v++) begin
            n = 8'(($random(seed) & 7) + 1);
            // park far from zero so the load-address clear cannot meet a wrap
            bus_wr(cbt_pkg::OFS_LATCH_HIGH, 8'hFF);
            load(n, 8'h00);
            // enable only after the clear, so a stale flag raises nothing
            bus_wr(cbt_pkg::OFS_CONTROL, 8'(8'h40 | (v << 5)));
            k = 0;
            while (irq !== 1'b1 && k < 3000) begin
                @(posedge clk_sys);
                k++;
            end
            chk(16'(k), 16'(n));
            chk({14'h0, ram_v, rom_v}, v ? 16'h2 : 16'h1);
            rd_chk(cbt_pkg::OFS_CONTROL, 8'(8'hC0 | (v << 5)));
            bus_wr(cbt_pkg::OFS_CONTROL, 8'(v << 5));
            @(posedge clk_sys);
            chk({15'h0, irq}, 16'h0);
        end
        // flag still set: 0x16 reloads without clearing it
        bus_wr(cbt_pkg::OFS_LATCH_LOW, 8'hF0);
        bus_wr(cbt_pkg::OFS_LATCH_HIGH, 8'h40);
        rd_chk(cbt_pkg::OFS_CONTROL, 8'hA0);
        bus_rd(cbt_pkg::OFS_LATCH_LOW, d);
        rd_chk(cbt_pkg::OFS_LATCH_HIGH, 8'h40);
        rd_chk(cbt_pkg::OFS_LATCH_LOAD, 8'h40);
        rd_chk(cbt_pkg::OFS_CONTROL, 8'h20);
        load(8'hFF, 8'h7F);
        rd_chk(cbt_pkg::OFS_CONTROL, 8'h20);
        // square wave, undivided then divided clock
        timer_mode <= cbt_pkg::MODE_PULSE;
        for (int p = 0; p < 2; p++) begin
            n = 8'(($random(seed) & 7) + 1);
            bus_wr(cbt_pkg::OFS_CONTROL, p ? 8'h04 : 8'h00);
            load(n, 8'h00);
            chk({14'h0, pin_out, oe_n}, 16'h0);
            toggle_gap(k);
            chk(16'(k), exp_gap(n, p != 0));
            rd_chk(cbt_pkg::OFS_CONTROL, p ? 8'h84 : 8'h80);
        end
        // event counting from the pin source, undivided clock
        timer_mode <= cbt_pkg::MODE_EVENT;
        bus_wr(cbt_pkg::OFS_CONTROL, 8'h00);
        n = 8'(($random(seed) & 3) + 1);
        load(n, 8'h00);
        for (int e = 0; e <= int'(n); e++) begin
            if (e == int'(n)) begin
                rd_chk(cbt_pkg::OFS_CONTROL, 8'h00);
            end
            pulse_go <= 1'b1;
            @(posedge clk_sys);
            pulse_go <= 1'b0;
            repeat (12) @(posedge clk_sys);
        end
        rd_chk(cbt_pkg::OFS_CONTROL, 8'h80);
        // width: hold while pin high, count while low
        timer_mode <= cbt_pkg::MODE_WIDTH;
        level_hi <= 1'b1;
        load(8'h03, 8'h00);
        repeat (40) @(posedge clk_sys);
        chk({15'h0, oe_n}, 16'h1);
        rd_chk(cbt_pkg::OFS_CONTROL, 8'h00);
        level_hi <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rd_chk(cbt_pkg::OFS_CONTROL, 8'h80);
        end_sim();
    end
endmodule : tb
`default_nettype wire
